// file: logic/adc_offset_mode_config_regs.v
// Configuration registers of a dual-channel converter with offset loop.
// Assumes a classic Wishbone master and synchronous sample inputs.
`timescale 1ns/10ps
`default_nettype none
`include "offset_cfg_defines.vh"

module adc_offset_mode_config_regs (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [31:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Channel samples
    input wire [13:0] chan_a_raw_i,
    input wire [13:0] chan_b_raw_i,
    output wire [13:0] chan_a_data_o,
    output wire [13:0] chan_b_data_o,
    // Mode controls
    output reg chan_a_slow_rate_o,
    output reg chan_b_slow_rate_o,
    output reg swing_override_o,
    output reg [5:0] fast_sample_tune_o
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg [7:0] fast_sample_tune_a;
    reg [7:0] chan_a_level_shift;
    reg [7:0] chan_b_level_shift;
    reg [7:0] offset_loop_cfg;
    reg [7:0] fast_sample_tune_b;
    reg [7:0] fast_sample_tune_c;
    reg [7:0] fast_tune_d_chb_slow;
    reg [7:0] slow_rate_master;
    reg [7:0] swing_override_cfg;
    reg [7:0] chan_a_slow_rate_cfg;
    reg [7:0] offset_loop_ctl;
    reg [7:0] digital_ctl;
    reg [7:0] next_rdata;
    reg hit;

    wire req;
    wire wr;
    wire [7:0] index;
    wire word_ok;
    wire offset_loop_enable;
    wire hold_offset_estimate;
    wire [3:0] offset_loop_period;
    wire step;

    assign req = cyc_i && stb_i && !ack_o;
    assign index = adr_i[9:2];
    assign word_ok = (adr_i[31:10] == 22'h000000) && (adr_i[1:0] == 2'h0);
    assign wr = req && we_i && sel_i[0] && word_ok;

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Tuning byte A; byte lane 0 carries every register
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_sample_tune_a <= `REG_RESET;
        end else if (wr && index == `IDX_FAST_SAMPLE_TUNE_A) begin
            fast_sample_tune_a <= dat_i[7:0];
        end
    end

    // Channel A level shift
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_a_level_shift <= `REG_RESET;
        end else if (wr && index == `IDX_CHAN_A_LEVEL_SHIFT) begin
            chan_a_level_shift <= dat_i[7:0];
        end
    end

    // Channel B level shift
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_b_level_shift <= `REG_RESET;
        end else if (wr && index == `IDX_CHAN_B_LEVEL_SHIFT) begin
            chan_b_level_shift <= dat_i[7:0];
        end
    end

    // Loop hold bit and period field
    always @(posedge clk_i) begin
        if (rst_i) begin
            offset_loop_cfg <= `REG_RESET;
        end else if (wr && index == `IDX_OFFSET_LOOP_CFG) begin
            offset_loop_cfg <= dat_i[7:0];
        end
    end

    // Tuning byte B
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_sample_tune_b <= `REG_RESET;
        end else if (wr && index == `IDX_FAST_SAMPLE_TUNE_B) begin
            fast_sample_tune_b <= dat_i[7:0];
        end
    end

    // Tuning byte C
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_sample_tune_c <= `REG_RESET;
        end else if (wr && index == `IDX_FAST_SAMPLE_TUNE_C) begin
            fast_sample_tune_c <= dat_i[7:0];
        end
    end

    // Tuning byte D and channel B slow-rate bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_tune_d_chb_slow <= `REG_RESET;
        end else if (wr && index == `IDX_FAST_TUNE_D_CHB_SLOW) begin
            fast_tune_d_chb_slow <= dat_i[7:0];
        end
    end

    // Slow-rate master enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            slow_rate_master <= `REG_RESET;
        end else if (wr && index == `IDX_SLOW_RATE_MASTER) begin
            slow_rate_master <= dat_i[7:0];
        end
    end

    // Swing override field
    always @(posedge clk_i) begin
        if (rst_i) begin
            swing_override_cfg <= `REG_RESET;
        end else if (wr && index == `IDX_SWING_OVERRIDE_CFG) begin
            swing_override_cfg <= dat_i[7:0];
        end
    end

    // Channel A slow-rate bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_a_slow_rate_cfg <= `REG_RESET;
        end else if (wr && index == `IDX_CHAN_A_SLOW_RATE_CFG) begin
            chan_a_slow_rate_cfg <= dat_i[7:0];
        end
    end

    // Offset loop enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            offset_loop_ctl <= `REG_RESET;
        end else if (wr && index == `IDX_OFFSET_LOOP_EN) begin
            offset_loop_ctl <= dat_i[7:0];
        end
    end

    // Digital function enable
    always @(posedge clk_i) begin
        if (rst_i) begin
            digital_ctl <= `REG_RESET;
        end else if (wr && index == `IDX_DIGITAL_EN) begin
            digital_ctl <= dat_i[7:0];
        end
    end

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    // Stored bytes read back as written; status shows loop state
    always @* begin
        next_rdata = 8'h00;
        hit = 1'b1;
        case (index)
            `IDX_FAST_SAMPLE_TUNE_A: next_rdata = fast_sample_tune_a;
            `IDX_CHAN_A_LEVEL_SHIFT: next_rdata = chan_a_level_shift;
            `IDX_CHAN_B_LEVEL_SHIFT: next_rdata = chan_b_level_shift;
            `IDX_OFFSET_LOOP_CFG: next_rdata = offset_loop_cfg;
            `IDX_FAST_SAMPLE_TUNE_B: next_rdata = fast_sample_tune_b;
            `IDX_FAST_SAMPLE_TUNE_C: next_rdata = fast_sample_tune_c;
            `IDX_FAST_TUNE_D_CHB_SLOW: next_rdata = fast_tune_d_chb_slow;
            `IDX_SLOW_RATE_MASTER: next_rdata = slow_rate_master;
            `IDX_SWING_OVERRIDE_CFG: next_rdata = swing_override_cfg;
            `IDX_CHAN_A_SLOW_RATE_CFG: next_rdata = chan_a_slow_rate_cfg;
            `IDX_OFFSET_LOOP_EN: next_rdata = offset_loop_ctl;
            `IDX_DIGITAL_EN: next_rdata = digital_ctl;
            `IDX_LOOP_STATUS: next_rdata = {5'h00, step, hold_offset_estimate,
                                            offset_loop_enable};
            default: hit = 1'b0;
        endcase
        if (!word_ok) begin
            hit = 1'b0;
        end
    end

    // Single-wait-state answer, one pulse per request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // Read data captured with the request, unmapped reads return zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (req && !we_i) begin
            dat_o <= hit ? {24'h000000, next_rdata} : `UNMAPPED_READ;
        end
    end

    // ****************************************************************
    // Offset loop control
    // ****************************************************************
    assign offset_loop_enable = offset_loop_ctl[`LOOP_EN_BIT]
                                && digital_ctl[`DIGITAL_EN_BIT];
    assign hold_offset_estimate = offset_loop_cfg[`HOLD_BIT];
    assign offset_loop_period = offset_loop_cfg[`PERIOD_MSB:`PERIOD_LSB];

    // Loop step pacing from the period field
    level_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(offset_loop_enable),
        .period_i(offset_loop_period),
        .step_o(step)
    );

    // Channel A correction
    offset_channel u_chan_a (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(offset_loop_enable),
        .hold_i(hold_offset_estimate),
        .step_i(step),
        .shift_i(chan_a_level_shift[`SHIFT_MSB:`SHIFT_LSB]),
        .raw_i(chan_a_raw_i),
        .data_o(chan_a_data_o),
        .estimate_o()
    );

    // Channel B correction
    offset_channel u_chan_b (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .active_i(offset_loop_enable),
        .hold_i(hold_offset_estimate),
        .step_i(step),
        .shift_i(chan_b_level_shift[`SHIFT_MSB:`SHIFT_LSB]),
        .raw_i(chan_b_raw_i),
        .data_o(chan_b_data_o),
        .estimate_o()
    );

    // ****************************************************************
    // Mode outputs
    // ****************************************************************
    // Slow-rate levels, gated by the master bit
    always @(posedge clk_i) begin
        if (rst_i) begin
            chan_a_slow_rate_o <= 1'b0;
            chan_b_slow_rate_o <= 1'b0;
        end else begin
            chan_a_slow_rate_o <= slow_rate_master[`SLOW_MASTER_BIT]
                && chan_a_slow_rate_cfg[`CHA_SLOW_BIT];
            chan_b_slow_rate_o <= slow_rate_master[`SLOW_MASTER_BIT]
                && fast_tune_d_chb_slow[`CHB_SLOW_BIT];
        end
    end

    // Swing override only for the enabling code
    always @(posedge clk_i) begin
        if (rst_i) begin
            swing_override_o <= 1'b0;
        end else begin
            swing_override_o <= (swing_override_cfg[`SWING_MSB:`SWING_LSB]
                == `SWING_ON);
        end
    end

    // Six tuning bits gathered from four bytes
    always @(posedge clk_i) begin
        if (rst_i) begin
            fast_sample_tune_o <= 6'h00;
        end else begin
            fast_sample_tune_o <= {fast_tune_d_chb_slow[`TUNE8_BIT],
                                   fast_sample_tune_c[`TUNE7_BIT],
                                   fast_sample_tune_c[`TUNE6_BIT],
                                   fast_sample_tune_b[`TUNE5_BIT],
                                   fast_sample_tune_b[`TUNE4_BIT],
                                   fast_sample_tune_a[`TUNE3_BIT]};
        end
    end
endmodule // adc_offset_mode_config_regs

`default_nettype wire

// file: logic/offset_cfg_defines.vh
// Register offsets, field positions, reset values and loop constants
// of the converter configuration group.
// Assumes inclusion by bare name from the design files.
`ifndef OFFSET_CFG_DEFINES_VH
`define OFFSET_CFG_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_FAST_SAMPLE_TUNE_A 8'h02
`define IDX_CHAN_A_LEVEL_SHIFT 8'hBF
`define IDX_CHAN_B_LEVEL_SHIFT 8'hC1
`define IDX_OFFSET_LOOP_CFG 8'hCF
`define IDX_FAST_SAMPLE_TUNE_B 8'hD5
`define IDX_FAST_SAMPLE_TUNE_C 8'hD7
`define IDX_FAST_TUNE_D_CHB_SLOW 8'hDB
`define IDX_SLOW_RATE_MASTER 8'hEF
`define IDX_SWING_OVERRIDE_CFG 8'hF1
`define IDX_CHAN_A_SLOW_RATE_CFG 8'hF2
`define IDX_OFFSET_LOOP_EN 8'h3D
`define IDX_DIGITAL_EN 8'h42
`define IDX_LOOP_STATUS 8'h60

// ****************************************************************
// Reset value and field positions
// ****************************************************************
`define REG_RESET 8'h00
`define SHIFT_MSB 7
`define SHIFT_LSB 2
`define HOLD_BIT 7
`define PERIOD_MSB 5
`define PERIOD_LSB 2
`define SLOW_MASTER_BIT 4
`define CHA_SLOW_BIT 3
`define CHB_SLOW_BIT 0
`define LOOP_EN_BIT 5
`define DIGITAL_EN_BIT 3
`define SWING_MSB 1
`define SWING_LSB 0
`define SWING_OFF 2'h0
`define SWING_ON 2'h3
`define TUNE3_BIT 6
`define TUNE4_BIT 4
`define TUNE5_BIT 3
`define TUNE6_BIT 3
`define TUNE7_BIT 2
`define TUNE8_BIT 5

// ****************************************************************
// Data path and loop constants
// ****************************************************************
`define CODE_W 14
`define MIDCODE 14'h2000
`define UNMAPPED_READ 32'h00000000

`endif

// file: logic/level_divider.v
// Programmable divider giving a one-cycle loop step enable.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module level_divider (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire run_i,
    input wire [3:0] period_i,
    // Step pulse
    output wire step_o
);
    reg [3:0] count;

    // ****************************************************************
    // Count period plus one cycles per step
    // ****************************************************************
    // Down counter reloaded from the period field
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            count <= 4'h0;
        end else if (count == 4'h0) begin
            count <= period_i;
        end else begin
            count <= count - 4'h1;
        end
    end

    assign step_o = run_i && (count == 4'h0);
endmodule // level_divider

`default_nettype wire

// file: logic/offset_channel.v
// One channel of offset correction: estimate, hold and level shift.
// Assumes a step pulse from the loop divider and synchronous samples.
`timescale 1ns/10ps
`default_nettype none
`include "offset_cfg_defines.vh"

module offset_channel (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire active_i,
    input wire hold_i,
    input wire step_i,
    input wire [5:0] shift_i,
    // Samples
    input wire [13:0] raw_i,
    output reg [13:0] data_o,
    output wire [13:0] estimate_o
);
    reg [13:0] estimate;
    wire [13:0] target;
    wire [13:0] corrected;

    // Target is midcode plus the signed shift, -32..+31
    assign target = `MIDCODE + {{8{shift_i[5]}}, shift_i};
    assign corrected = raw_i - estimate + (target - `MIDCODE);
    assign estimate_o = estimate;

    // ****************************************************************
    // Estimate tracks the offset from midcode
    // ****************************************************************
    // Unit step toward the residual error, frozen while held
    always @(posedge clk_i) begin
        if (rst_i || !active_i) begin
            estimate <= 14'h0000;
        end else if (step_i && !hold_i) begin
            if ($signed(raw_i - estimate - `MIDCODE) > 0) begin
                estimate <= estimate + 14'h0001;
            end else if ($signed(raw_i - estimate - `MIDCODE) < 0) begin
                estimate <= estimate - 14'h0001;
            end
        end
    end

    // Registered output, bypass when inactive
    always @(posedge clk_i) begin
        if (rst_i) begin
            data_o <= 14'h0000;
        end else if (active_i) begin
            data_o <= corrected;
        end else begin
            data_o <= raw_i;
        end
    end
endmodule // offset_channel

`default_nettype wire

// file: verif/adc_offset_mode_config_regs_properties.sv
// Checker for the bus handshake, reset state and mode outputs.
// Assumes binding to the register bank top; one clock, sync reset.
`timescale 1ns/10ps
`default_nettype none
module adc_offset_mode_config_regs_checker (
    // Clock, reset and bus
    input wire logic clk_i, input wire logic rst_i,
    input wire logic cyc_i, input wire logic stb_i, input wire logic we_i,
    input wire logic [31:0] adr_i, input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i, input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Samples and modes
    input wire logic [13:0] chan_a_raw_i, input wire logic [13:0] chan_b_raw_i,
    input wire logic [13:0] chan_a_data_o, input wire logic [13:0] chan_b_data_o,
    input wire logic chan_a_slow_rate_o, input wire logic chan_b_slow_rate_o,
    input wire logic swing_override_o, input wire logic [5:0] fast_sample_tune_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ************************************************
    // Request decode
    // ************************************************
    wire take = cyc_i & stb_i & !ack_o;
    wire wr_on = take & we_i & sel_i[0];
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_ack_answer: assert property (take |=> ack_o) else $error("request not answered");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i & stb_i))
        else $error("ack with no request");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o &&
        !swing_override_o && fast_sample_tune_o == 6'h00 && chan_a_data_o == 14'h0000)
        else $error("outputs not clear after reset");
    a_upper_zero: assert property (dat_o[31:8] == 24'h000000) else $error("read upper bits set");
    a_swing_on: assert property (wr_on && adr_i == 32'h000003C4 && dat_i[1:0] == 2'h3
        |-> ##[1:2] swing_override_o) else $error("swing override not enabled");
    a_swing_off: assert property (wr_on && adr_i == 32'h000003C4 && dat_i[1:0] != 2'h3
        |-> ##[1:2] !swing_override_o) else $error("swing override wrongly enabled");
    a_tune_three: assert property (wr_on && adr_i == 32'h00000008
        |-> ##2 fast_sample_tune_o[0] == $past(dat_i[6], 2)) else $error("tune bit mismatch");
    a_unmapped_zero: assert property (take && !we_i && adr_i == 32'h000003FC
        |=> dat_o == 32'h00000000) else $error("unmapped read not zero");
endmodule // adc_offset_mode_config_regs_checker
`default_nettype wire

// file: verif/adc_offset_mode_config_regs_tb.sv
// Self-checking bench of the converter configuration registers.
// Assumes the design and its defines header on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "offset_cfg_defines.vh"
module adc_offset_mode_config_regs_tb;
    // ************************************************
    // Stimulus and observed signals
    // ************************************************
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [31:0] adr_i = 32'h0, dat_i = 32'h0, rd, dat_o;
    logic [3:0] sel_i = 4'hF;
    logic [13:0] a_raw = 14'h0000, b_raw = 14'h0000, a_out, b_out;
    logic ack_o, a_slow, b_slow, swing;
    logic [5:0] tune;
    int fail_count = 0, n_compared = 0;
    logic [7:0] idx_t [10] = '{8'h02, 8'hBF, 8'hC1, 8'hCF, 8'hD5, 8'hD7, 8'hEF,
        8'hDB, 8'hF1, 8'hF2};
    logic [7:0] wr_t [10] = '{8'h40, 8'h80, 8'h7C, 8'h00, 8'h18, 8'h0C, 8'h10,
        8'h21, 8'h00, 8'h08};
    adc_offset_mode_config_regs adc_offset_mode_config_regs_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .chan_a_raw_i(a_raw), .chan_b_raw_i(b_raw),
        .chan_a_data_o(a_out), .chan_b_data_o(b_out), .chan_a_slow_rate_o(a_slow),
        .chan_b_slow_rate_o(b_slow), .swing_override_o(swing), .fast_sample_tune_o(tune));
    // Clock of 100 ns period
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {22'h000000, idx, 2'b00};
        dat_i <= {24'h000000, wd};
        for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
        if (ack_o !== 1'b1) begin
            fail_count++;
            wrap_up();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic t_reset();
        foreach (idx_t[i]) begin
            wb(1'b0, idx_t[i], 8'h00);
            chk("reset value", 32'h0, rd);
        end
        wb(1'b0, 8'hFF, 8'h00);
        chk("unmapped read", 32'h0, rd);
        $display("test reset done");
    endtask
    task automatic t_regs();
        foreach (idx_t[i]) wb(1'b1, idx_t[i], wr_t[i]);
        foreach (idx_t[i]) begin
            wb(1'b0, idx_t[i], 8'h00);
            chk("readback", {24'h0, wr_t[i]}, rd);
        end
        chk("tune bits", 32'h3F, tune);
        chk("slow a on", 32'h1, a_slow);
        chk("slow b on", 32'h1, b_slow);
        wb(1'b1, 8'hEF, 8'h00);
        chk("slow a gated", 32'h0, a_slow);
        chk("slow b gated", 32'h0, b_slow);
        wb(1'b1, 8'hEF, 8'h10);
        wb(1'b1, 8'hF2, 8'h00);
        chk("slow a off", 32'h0, a_slow);
        chk("slow b kept", 32'h1, b_slow);
        $display("test registers done");
    endtask
    task automatic t_swing();
        for (int v = 0; v < 4; v++) begin
            wb(1'b1, 8'hF1, {6'h00, {2{v[0]}}});
            chk("swing override", {31'h0, v[0]}, swing);
        end
        $display("test swing done");
    endtask
    task automatic t_data();
        a_raw <= 14'h1234;
        b_raw <= 14'h0ABC;
        tick(4);
        chk("pass a", 32'h1234, a_out);
        wb(1'b1, 8'h3D, 8'h20);
        tick(4);
        chk("pass b", 32'h0ABC, b_out);
        a_raw <= `MIDCODE;
        b_raw <= `MIDCODE;
        tick(2);
        wb(1'b1, 8'h42, 8'h08);
        tick(6);
        chk("shift a", 32'h1FE0, a_out);
        chk("shift b", 32'h201F, b_out);
        wb(1'b1, 8'hCF, 8'h80);
        a_raw <= `MIDCODE + 14'h0005;
        tick(40);
        chk("frozen a", 32'h1FE5, a_out);
        wb(1'b1, 8'hCF, 8'h3C);
        tick(40);
        chk("slow track a", 32'h1FE2, a_out);
        tick(40);
        chk("tracked a", 32'h1FE0, a_out);
        wb(1'b1, 8'h3D, 8'h00);
        tick(2);
        chk("loop off a", 32'h2005, a_out);
        $display("test data path done");
    endtask
    task automatic t_rereset();
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        chk("modes after reset", 32'h0, {swing, a_slow, b_slow, tune});
        t_reset();
        $display("test second reset done");
    endtask
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_swing();
        t_data();
        t_rereset();
        wrap_up();
    end
endmodule // adc_offset_mode_config_regs_tb
bind adc_offset_mode_config_regs adc_offset_mode_config_regs_checker chk_i (.clk_i(clk_i),
    .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chan_a_raw_i(chan_a_raw_i),
    .chan_b_raw_i(chan_b_raw_i), .chan_a_data_o(chan_a_data_o), .chan_b_data_o(chan_b_data_o),
    .chan_a_slow_rate_o(chan_a_slow_rate_o), .chan_b_slow_rate_o(chan_b_slow_rate_o),
    .swing_override_o(swing_override_o), .fast_sample_tune_o(fast_sample_tune_o));
`default_nettype wire
